// [core/wfd_detector.sv]
// wake-up frame filters and wake-pattern packet detector
//
// Functional notes
// - command bit 3 limits a filter to multicast when set, unicast when clear.
// - a filter only matches while its command enable bit is set.
// - the 8-bit offset gives the first crc byte; zero is first address byte.
// - crc over masked bytes equal to programmed crc means a wake frame.
// - pattern enable stops normal reception and starts pattern search.
// - a pattern hit raises the interrupt or power event, as selected.
// - a pattern hit sets the pattern received status bit.
// - clearing pattern enable resumes normal reception.
// - pattern search only in frames to own, broadcast or multicast address.
// - after the address fields, look for six bytes of all ones.
// - sixteen unbroken station address copies must follow the sync run.
// - a broken copy run restarts the search for a sync run.
// - copies may sit anywhere but need a sync run directly before.
// - multicast frames also count when they hold the sixteen copies.
// - in full power, pattern search runs only while enabled.
// - low power enables both detectors regardless of enable bits.
// - frame enable stops reception; a match sets frame received status.
// - mask bit j includes byte offset plus j in the filter crc.
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module wfd_detector (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   // receive byte stream
   input wire wfd_pkg::wfd_rx_s rx,
   // power state
   input wire logic lowPower,
   // results
   output logic normalRxEn,
   output logic wakeIrq,
   output logic power_event_out
);
   // ==========================================================
   // state
   typedef struct packed {
      logic patEn;
      logic frmEn;
      logic notifyPme;
      logic patRcv;
      logic frmRcv;
      logic [47:0] station;
      logic [wfd_pkg::FILT_WORDS-1:0][31:0] filt;
      logic [2:0] filtPtr;
      logic [31:0] rdData;
      logic [8:0] byteCnt;
      logic daSta;
      logic daBc;
      logic daMc;
      wfd_pkg::wfd_pat_e patState;
      logic [2:0] ffCnt;
      logic [2:0] addrIdx;
      logic [3:0] copyCnt;
      logic [wfd_pkg::NUM_FILT-1:0][15:0] crc;
   } wfd_state_s;

   wfd_state_s s_r;
   wfd_state_s s_nxt;
   logic patActive;
   logic frmActive;
   logic [8:0] pos;
   logic patSet;
   logic frmSet;
   logic [wfd_pkg::NUM_FILT-1:0] hit;
   logic [wfd_pkg::NUM_FILT-1:0] incl;
   logic [wfd_pkg::NUM_FILT-1:0][15:0] crcIn;
   logic [wfd_pkg::NUM_FILT-1:0][15:0] crcNext;
   logic [wfd_pkg::NUM_FILT-1:0][15:0] crcAfter;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   // ==========================================================
   // modes
   assign patActive = s_r.patEn | lowPower;
   assign frmActive = s_r.frmEn | lowPower;
   assign normalRxEn = !(patActive | frmActive);
   assign pos = rx.sof ? 9'h000 : s_r.byteCnt;
   assign regRdata = s_r.rdData;
   assign wakeIrq = !s_r.notifyPme & (s_r.patRcv | s_r.frmRcv);
   assign power_event_out = s_r.notifyPme & (s_r.patRcv | s_r.frmRcv);

   // ==========================================================
   // wake-up frame filters
   for (genvar i = 0; i < wfd_pkg::NUM_FILT; i++) begin : g_filt
      logic [7:0] cmd;
      logic [7:0] ofs;
      logic [15:0] crcRef;
      logic [8:0] rel;
      logic addrOk;
      assign cmd = s_r.filt[wfd_pkg::FW_CMD][8*i +: 8];
      assign ofs = s_r.filt[wfd_pkg::FW_OFS][8*i +: 8];
      assign crcRef = s_r.filt[wfd_pkg::FW_CRC + 3'(i/2)][16*(i%2) +: 16];
      assign rel = pos - {1'b0, ofs};
      assign incl[i] = (pos >= {1'b0, ofs}) && (rel < 9'(wfd_pkg::MASK_BITS))
         && s_r.filt[i][rel[4:0]];
      assign crcIn[i] = rx.sof ? wfd_pkg::CRC_INIT : s_r.crc[i];
      wfd_crc16_byte u_crc (
         .crcIn(crcIn[i]),
         .data(rx.data),
         .crcOut(crcNext[i])
      );
      assign crcAfter[i] = incl[i] ? crcNext[i] : crcIn[i];
      assign addrOk = cmd[wfd_pkg::CMD_MCAST] ? s_r.daMc : s_r.daSta;
      assign hit[i] = cmd[wfd_pkg::CMD_ENABLE] && addrOk
         && (crcAfter[i] == crcRef);

      filt_off_a: assert property (!cmd[wfd_pkg::CMD_ENABLE] |-> !hit[i])
         else $error("disabled filter matched");
      addr_type_a: assert property (hit[i] && cmd[wfd_pkg::CMD_MCAST] |-> s_r.daMc)
         else $error("multicast filter hit on unicast frame");
      crc_eq_a: assert property (hit[i] |-> crcAfter[i] == crcRef)
         else $error("filter hit without crc equality");
      offset_a: assert property (incl[i] |-> pos >= {1'b0, ofs} && rel <= 9'h01E)
         else $error("crc byte outside offset window");
   end

   assign frmSet = frmActive && rx.valid && rx.eof && (|hit);

   // ==========================================================
   // next state
   always_comb begin
      logic [7:0] staByte;
      logic found;
      s_nxt = s_r;
      staByte = 8'h00;
      found = 1'b0;
      patSet = 1'b0;

      // receive path
      if (rx.valid) begin
         s_nxt.byteCnt = (pos == wfd_pkg::POS_MAX) ? pos : pos + 9'h001;
         for (int i = 0; i < wfd_pkg::NUM_FILT; i++) begin
            s_nxt.crc[i] = crcAfter[i];
         end
         if (pos < wfd_pkg::DA_LEN) begin
            staByte = s_r.station[8*pos[2:0] +: 8];
            s_nxt.daSta = (rx.sof | s_r.daSta) & (rx.data == staByte);
            s_nxt.daBc = (rx.sof | s_r.daBc) & (rx.data == wfd_pkg::SYNC_BYTE);
            if (rx.sof) begin
               s_nxt.daMc = rx.data[0];
            end
         end
         if (pos < wfd_pkg::HDR_LEN) begin
            // addresses are never part of the pattern
            s_nxt.patState = wfd_pkg::WFD_HUNT;
            s_nxt.ffCnt = 3'h0;
            s_nxt.addrIdx = 3'h0;
            s_nxt.copyCnt = 4'h0;
         end else begin
            staByte = s_r.station[8*s_r.addrIdx +: 8];
            case (s_r.patState)
               wfd_pkg::WFD_HUNT: begin
                  if (rx.data == wfd_pkg::SYNC_BYTE) begin
                     if (s_r.ffCnt == wfd_pkg::SYNC_LAST) begin
                        s_nxt.patState = wfd_pkg::WFD_COPY;
                        s_nxt.ffCnt = 3'h0;
                        s_nxt.addrIdx = 3'h0;
                        s_nxt.copyCnt = 4'h0;
                     end else begin
                        s_nxt.ffCnt = s_r.ffCnt + 3'h1;
                     end
                  end else begin
                     s_nxt.ffCnt = 3'h0;
                  end
               end
               wfd_pkg::WFD_COPY: begin
                  if (rx.data == staByte) begin
                     if (s_r.addrIdx == wfd_pkg::ADDR_LAST) begin
                        s_nxt.addrIdx = 3'h0;
                        if (s_r.copyCnt == wfd_pkg::COPY_LAST) begin
                           found = 1'b1;
                           s_nxt.patState = wfd_pkg::WFD_HUNT;
                        end else begin
                           s_nxt.copyCnt = s_r.copyCnt + 4'h1;
                        end
                     end else begin
                        s_nxt.addrIdx = s_r.addrIdx + 3'h1;
                     end
                  end else if (rx.data == wfd_pkg::SYNC_BYTE && s_r.addrIdx == 3'h0
                               && s_r.copyCnt == 4'h0) begin
                     // sync run longer than six bytes
                     s_nxt.patState = wfd_pkg::WFD_COPY;
                  end else begin
                     // broken copy run: hunt again
                     s_nxt.patState = wfd_pkg::WFD_HUNT;
                     s_nxt.addrIdx = 3'h0;
                     s_nxt.copyCnt = 4'h0;
                     s_nxt.ffCnt = (rx.data == wfd_pkg::SYNC_BYTE) ? 3'h1 : 3'h0;
                  end
               end
               default: begin
                  s_nxt.patState = wfd_pkg::WFD_HUNT;
               end
            endcase
         end
         patSet = found && patActive
            && (s_r.daSta || s_r.daBc || s_r.daMc);
      end

      // register writes
      if (regWr) begin
         if (regAddr == wfd_pkg::ADDR_CTRL) begin
            s_nxt.patEn = regWdata[wfd_pkg::CTL_PAT_EN];
            s_nxt.frmEn = regWdata[wfd_pkg::CTL_FRM_EN];
            s_nxt.notifyPme = regWdata[wfd_pkg::CTL_NOTIFY_PME];
            s_nxt.patRcv = s_r.patRcv & !regWdata[wfd_pkg::CTL_PAT_RCV];
            s_nxt.frmRcv = s_r.frmRcv & !regWdata[wfd_pkg::CTL_FRM_RCV];
         end else if (regAddr == wfd_pkg::ADDR_STA_LO) begin
            s_nxt.station[31:0] = regWdata;
         end else if (regAddr == wfd_pkg::ADDR_STA_HI) begin
            s_nxt.station[47:32] = regWdata[15:0];
         end else if (regAddr == wfd_pkg::ADDR_FILT_PORT) begin
            // sequential loading port walks the eight table words
            s_nxt.filt[s_r.filtPtr] = regWdata & ((s_r.filtPtr < wfd_pkg::FW_CMD)
               ? wfd_pkg::MASK_WMASK : (s_r.filtPtr == wfd_pkg::FW_CMD)
               ? wfd_pkg::CMD_WMASK : 32'hFFFFFFFF);
            s_nxt.filtPtr = s_r.filtPtr + 3'h1;
         end else if (regAddr >= wfd_pkg::ADDR_FILT_BASE && regAddr <= wfd_pkg::ADDR_FILT_LAST
                      && regAddr[1:0] == 2'b00) begin
            s_nxt.filt[regAddr[4:2]] = regWdata & ((regAddr[4:2] < wfd_pkg::FW_CMD)
               ? wfd_pkg::MASK_WMASK : (regAddr[4:2] == wfd_pkg::FW_CMD)
               ? wfd_pkg::CMD_WMASK : 32'hFFFFFFFF);
         end
      end

      // status set wins over clear
      if (patSet) begin
         s_nxt.patRcv = 1'b1;
      end
      if (frmSet) begin
         s_nxt.frmRcv = 1'b1;
      end

      // register reads
      s_nxt.rdData = 32'h00000000;
      if (regRd) begin
         if (regAddr == wfd_pkg::ADDR_CTRL) begin
            s_nxt.rdData[wfd_pkg::CTL_PAT_EN] = s_r.patEn;
            s_nxt.rdData[wfd_pkg::CTL_FRM_EN] = s_r.frmEn;
            s_nxt.rdData[wfd_pkg::CTL_PAT_RCV] = s_r.patRcv;
            s_nxt.rdData[wfd_pkg::CTL_FRM_RCV] = s_r.frmRcv;
            s_nxt.rdData[wfd_pkg::CTL_NOTIFY_PME] = s_r.notifyPme;
         end else if (regAddr == wfd_pkg::ADDR_STA_LO) begin
            s_nxt.rdData = s_r.station[31:0];
         end else if (regAddr == wfd_pkg::ADDR_STA_HI) begin
            s_nxt.rdData[15:0] = s_r.station[47:32];
         end else if (regAddr == wfd_pkg::ADDR_FILT_PORT) begin
            s_nxt.rdData[2:0] = s_r.filtPtr;
         end else if (regAddr >= wfd_pkg::ADDR_FILT_BASE && regAddr <= wfd_pkg::ADDR_FILT_LAST
                      && regAddr[1:0] == 2'b00) begin
            s_nxt.rdData = s_r.filt[regAddr[4:2]];
         end
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '{
            patEn: 1'b0, frmEn: 1'b0, notifyPme: 1'b0, patRcv: 1'b0, frmRcv: 1'b0,
            station: wfd_pkg::STA_RESET,
            filt: {wfd_pkg::FILT_WORDS{wfd_pkg::FILT_RESET}},
            filtPtr: 3'h0, rdData: 32'h00000000, byteCnt: 9'h000,
            daSta: 1'b0, daBc: 1'b0, daMc: 1'b0,
            patState: wfd_pkg::WFD_HUNT, ffCnt: 3'h0, addrIdx: 3'h0, copyCnt: 4'h0,
            crc: {wfd_pkg::NUM_FILT{wfd_pkg::CRC_INIT}}
         };
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // checks
   sequence patNotify;
      ##1 s_r.patRcv ##0 (wakeIrq || power_event_out);
   endsequence

   rx_stop_a: assert property ((s_r.patEn || s_r.frmEn || lowPower) |-> !normalRxEn)
      else $error("normal reception while a detector is enabled");
   pat_status_a: assert property (patSet |-> patNotify)
      else $error("pattern hit did not raise status and notify");
   notify_sel_a: assert property (s_r.patRcv && !s_r.notifyPme
      |-> wakeIrq && !power_event_out)
      else $error("wrong notify output");
   copy_count_a: assert property (patSet |-> s_r.patState == wfd_pkg::WFD_COPY
      && s_r.copyCnt == wfd_pkg::COPY_LAST && s_r.addrIdx == wfd_pkg::ADDR_LAST)
      else $error("pattern accepted before sixteen copies");
   pat_gate_a: assert property (patSet |-> s_r.patEn || lowPower)
      else $error("pattern hit while detection inactive");
   resume_rx_a: assert property (!s_r.patEn && !s_r.frmEn && !lowPower |-> normalRxEn)
      else $error("reception not resumed");
   hdr_skip_a: assert property (rx.valid && pos < wfd_pkg::HDR_LEN
      |=> s_r.patState == wfd_pkg::WFD_HUNT && s_r.ffCnt == 3'h0)
      else $error("sync search inside address fields");
   frm_status_a: assert property (frmSet |=> s_r.frmRcv)
      else $error("frame match did not set status");
endmodule : wfd_detector

// [core/wfd_pkg.sv]
// shared constants and types of the wake frame detector
package wfd_pkg;
   // ==========================================================
   // register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STA_LO = 8'h04;
   localparam logic [7:0] ADDR_STA_HI = 8'h08;
   localparam logic [7:0] ADDR_FILT_PORT = 8'h10;
   localparam logic [7:0] ADDR_FILT_BASE = 8'h20;
   localparam logic [7:0] ADDR_FILT_LAST = 8'h3C;
   // ==========================================================
   // wake control and status bits
   localparam int CTL_PAT_EN = 0;
   localparam int CTL_FRM_EN = 1;
   localparam int CTL_PAT_RCV = 4;
   localparam int CTL_FRM_RCV = 5;
   localparam int CTL_NOTIFY_PME = 8;
   // ==========================================================
   // filter table layout: words 0..3 masks, 4 commands, 5 offsets, 6..7 crcs
   localparam int NUM_FILT = 4;
   localparam int FILT_WORDS = 8;
   localparam logic [2:0] FW_CMD = 3'h4;
   localparam logic [2:0] FW_OFS = 3'h5;
   localparam logic [2:0] FW_CRC = 3'h6;
   localparam int CMD_ENABLE = 0;
   localparam int CMD_MCAST = 3;
   localparam int MASK_BITS = 31;
   localparam logic [31:0] MASK_WMASK = 32'h7FFFFFFF;
   localparam logic [31:0] CMD_WMASK = 32'h09090909;
   localparam logic [31:0] FILT_RESET = 32'h00000000;
   // ==========================================================
   // frame layout and pattern constants
   localparam logic [8:0] DA_LEN = 9'h006;
   localparam logic [8:0] HDR_LEN = 9'h00C;
   localparam logic [8:0] POS_MAX = 9'h1FF;
   localparam logic [7:0] SYNC_BYTE = 8'hFF;
   localparam logic [2:0] SYNC_LAST = 3'h5;
   localparam logic [2:0] ADDR_LAST = 3'h5;
   localparam logic [3:0] COPY_LAST = 4'hF;
   localparam logic [15:0] CRC_POLY = 16'h8005;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [47:0] STA_RESET = 48'h000000000000;

   typedef enum logic [1:0] {
      WFD_HUNT = 2'b01,
      WFD_COPY = 2'b10
   } wfd_pat_e;

   typedef struct packed {
      logic valid;
      logic sof;
      logic eof;
      logic [7:0] data;
   } wfd_rx_s;
endpackage : wfd_pkg

// [core/wfd_crc16_byte.sv]
// one-byte update of the wake filter crc-16
`timescale 1ns/1ps
module wfd_crc16_byte (
   // running value and byte
   input wire logic [15:0] crcIn,
   input wire logic [7:0] data,
   // updated value
   output logic [15:0] crcOut
);
   always_comb begin
      logic [15:0] c;
      logic fb;
      c = crcIn;
      fb = 1'b0;
      for (int k = 7; k >= 0; k--) begin
         fb = c[15] ^ data[k];
         c = {c[14:0], 1'b0} ^ (fb ? wfd_pkg::CRC_POLY : 16'h0000);
      end
      crcOut = c;
   end
endmodule : wfd_crc16_byte

// [dv/wfd_rx_model.sv]
// receive path model that plays frame bytes into the detector
`timescale 1ns/1ps
module wfd_rx_model (
   // clock
   input wire logic ref_clk,
   // byte stream towards the detector
   output wfd_pkg::wfd_rx_s rx
);
   initial begin
      rx = '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: 8'h00};
   end

   // ==========================================================
   // frame playback: sof on first byte, eof on last, wire order
   task automatic sendFrame(input logic [7:0] f[$]);
      for (int i = 0; i < f.size(); i++) begin
         @(posedge ref_clk);
         rx <= '{valid: 1'b1, sof: (i == 0), eof: (i == f.size() - 1), data: f[i]};
      end
      @(posedge ref_clk);
      // idle bus shows the inverse of the last byte, not a stale copy
      rx <= '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: ~f[f.size() - 1]};
   endtask : sendFrame
endmodule : wfd_rx_model

// [dv/wake_frame_detector_tb_top.sv]
// self-checking testbench of the wake frame detector
`timescale 1ns/1ps
module wake_frame_detector_tb_top;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h00000000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdata;
   wfd_pkg::wfd_rx_s rx;
   logic lowPower = 1'b0;
   logic normalRxEn;
   logic wakeIrq;
   logic powerEvent;
   int failures = 0;
   int n_tests = 0;
   logic [7:0] frm[$];
   logic [7:0] frmA[$];
   logic [7:0] frmB[$];
   localparam logic [47:0] STA = 48'h5A4B3C2D1E0E;

   always #4 ref_clk = ~ref_clk;

   wfd_detector uut (.ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rx(rx),
      .lowPower(lowPower), .normalRxEn(normalRxEn), .wakeIrq(wakeIrq),
      .power_event_out(powerEvent));
   wfd_rx_model mac (.ref_clk(ref_clk), .rx(rx));

   // ==========================================================
   // verdict and compare helpers
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : tally_and_finish

   task automatic chkWord(input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chkWord

   task automatic chkBit(input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chkBit

   // ==========================================================
   // register port: one-cycle strobes, data the cycle after a read
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
      #1;
   endtask : wr

   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1;
      chkWord(exp, regRdata);
   endtask : rdChk

   // ==========================================================
   // frame assembly and playback
   task automatic hdr(input logic [47:0] da);
      frm.delete();
      for (int k = 0; k < 6; k++) frm.push_back(da[8*k+:8]);
      for (int k = 0; k < 6; k++) frm.push_back(8'h10 + 8'(k));
   endtask : hdr

   task automatic sync();
      for (int k = 0; k < 6; k++) frm.push_back(8'hFF);
   endtask : sync

   task automatic copies(input int n);
      for (int c = 0; c < n; c++) for (int k = 0; k < 6; k++) frm.push_back(STA[8*k+:8]);
   endtask : copies

   task automatic play(input logic [7:0] f[$]);
      mac.sendFrame(f);
      repeat (3) @(posedge ref_clk);
      #1;
   endtask : play

   function automatic logic [15:0] crcOf(input logic [7:0] f[$], input int ofs,
                                          input logic [31:0] m);
      logic [15:0] c;
      logic fb;
      c = wfd_pkg::CRC_INIT;
      for (int i = ofs; i < ofs + 31; i++) begin
         if (m[i - ofs]) begin
            for (int b = 7; b >= 0; b--) begin
               fb = c[15] ^ f[i][b];
               c = {c[14:0], 1'b0};
               if (fb) c = c ^ wfd_pkg::CRC_POLY;
            end
         end
      end
      return c;
   endfunction : crcOf

   // ==========================================================
   // scenarios
   task automatic t_reset();
      rdChk(wfd_pkg::ADDR_CTRL, 32'h00000000);
      chkBit(1'b1, normalRxEn);
      rdChk(8'h0C, 32'h00000000);
      rdChk(wfd_pkg::ADDR_FILT_PORT, 32'h00000000);
      wr(wfd_pkg::ADDR_STA_LO, STA[31:0]);
      wr(wfd_pkg::ADDR_STA_HI, {16'h0000, STA[47:32]});
      rdChk(wfd_pkg::ADDR_STA_HI, {16'h0000, STA[47:32]});
      $display("test reset done");
   endtask : t_reset

   task automatic t_pattern();
      wr(wfd_pkg::ADDR_CTRL, 32'h00000001);
      chkBit(1'b0, normalRxEn);
      play(frmA);
      rdChk(wfd_pkg::ADDR_CTRL, 32'h00000011);
      chkBit(1'b1, wakeIrq);
      chkBit(1'b0, powerEvent);
      wr(wfd_pkg::ADDR_CTRL, 32'h00000111);
      chkBit(1'b0, wakeIrq);
      hdr(48'hFFFFFFFFFFFF);
      sync();
      copies(15);
      for (int k = 0; k < 3; k++) frm.push_back(STA[8*k+:8]);
      frm.push_back(8'h00);
      sync();
      copies(16);
      play(frm);
      rdChk(wfd_pkg::ADDR_CTRL, 32'h00000111);
      chkBit(1'b1, powerEvent);
      chkBit(1'b0, wakeIrq);
      wr(wfd_pkg::ADDR_CTRL, 32'h00000011);
      $display("test pattern done");
   endtask : t_pattern

   task automatic t_reject();
      hdr(48'h000000000002);
      sync();
      copies(16);
      play(frm);
      rdChk(wfd_pkg::ADDR_CTRL, 32'h00000001);
      hdr(STA);
      copies(16);
      frm.push_back(8'h00);
      play(frm);
      rdChk(wfd_pkg::ADDR_CTRL, 32'h00000001);
      play(frmB);
      rdChk(wfd_pkg::ADDR_CTRL, 32'h00000011);
      wr(wfd_pkg::ADDR_CTRL, 32'h00000010);
      chkBit(1'b1, normalRxEn);
      play(frmA);
      rdChk(wfd_pkg::ADDR_CTRL, 32'h00000000);
      $display("test reject done");
   endtask : t_reject

   task automatic t_filter();
      logic [15:0] c0;
      logic [15:0] c1;
      c0 = crcOf(frmA, 12, 32'h00F00005);
      c1 = crcOf(frmB, 14, 32'h00000F01);
      wr(wfd_pkg::ADDR_FILT_PORT, 32'h00F00005);
      wr(wfd_pkg::ADDR_FILT_PORT, 32'h00000F01);
      wr(wfd_pkg::ADDR_FILT_PORT, 32'h00000000);
      wr(wfd_pkg::ADDR_FILT_PORT, 32'hFFFFFFFF);
      wr(wfd_pkg::ADDR_FILT_PORT, 32'hF6F60801);
      wr(wfd_pkg::ADDR_FILT_PORT, 32'h0C0C0E0C);
      wr(wfd_pkg::ADDR_FILT_PORT, {c1, c0});
      wr(wfd_pkg::ADDR_FILT_PORT, 32'h00000000);
      rdChk(wfd_pkg::ADDR_FILT_PORT, 32'h00000000);
      rdChk(8'h2C, 32'h7FFFFFFF);
      rdChk(8'h30, 32'h00000801);
      wr(wfd_pkg::ADDR_CTRL, 32'h00000002);
      chkBit(1'b0, normalRxEn);
      play(frmB);
      rdChk(wfd_pkg::ADDR_CTRL, 32'h00000002);
      play(frmA);
      rdChk(wfd_pkg::ADDR_CTRL, 32'h00000022);
      chkBit(1'b1, wakeIrq);
      wr(wfd_pkg::ADDR_CTRL, 32'h00000022);
      wr(8'h30, 32'h00000900);
      play(frmA);
      rdChk(wfd_pkg::ADDR_CTRL, 32'h00000002);
      play(frmB);
      rdChk(wfd_pkg::ADDR_CTRL, 32'h00000022);
      wr(wfd_pkg::ADDR_CTRL, 32'h00000020);
      chkBit(1'b1, normalRxEn);
      $display("test filter done");
   endtask : t_filter

   task automatic t_lowpower();
      @(posedge ref_clk);
      lowPower <= 1'b1;
      #1;
      chkBit(1'b0, normalRxEn);
      play(frmB);
      rdChk(wfd_pkg::ADDR_CTRL, 32'h00000030);
      @(posedge ref_clk);
      lowPower <= 1'b0;
      wr(wfd_pkg::ADDR_CTRL, 32'h00000030);
      rdChk(wfd_pkg::ADDR_CTRL, 32'h00000000);
      $display("test lowpower done");
   endtask : t_lowpower

   // ==========================================================
   // main sequence and watchdog
   initial begin
      hdr(STA);
      sync();
      copies(16);
      frm.push_back(8'hA1);
      frm.push_back(8'hB2);
      frmA = frm;
      frmB = frm;
      frmB[0] = 8'h01;
      for (int k = 1; k < 6; k++) frmB[k] = 8'h00;
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'b1;
      #1;
      t_reset();
      t_pattern();
      t_reject();
      t_filter();
      t_lowpower();
      tally_and_finish();
   end

   initial begin
      repeat (50000) @(posedge ref_clk);
      failures++;
      tally_and_finish();
   end
endmodule : wake_frame_detector_tb_top
